// >>> hdl/driver_chain_datagram_sequencer.sv
`timescale 1ns/1ps
module driver_chain_datagram_sequencer
    import seq_pkg::*;
#(
    parameter int N_MOTORS = MOTORS
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  motor_sig_s       motor_sig [MOTORS],
    input  wire logic        tx_request,
    input  wire logic        link_clk,
    output logic             drv_data,
    output logic             drv_select_n
);
    if (N_MOTORS < 1 || N_MOTORS > MOTORS) begin : g_chk
        $error("N_MOTORS must be 1 to 3");
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [1:0]  last_q;
    logic        req_q;
    logic [11:0] ram_rdata;
    logic        bus_req;
    logic        is_cfg;
    logic        cfg_we;
    logic        ctrl_we;
    logic        start_wr;
    logic [11:0] wr_mask;

    assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
    assign is_cfg   = wb_adr_i[7] == CFG_OFS[7];
    assign cfg_we   = bus_req && wb_we_i && is_cfg;
    assign ctrl_we  = bus_req && wb_we_i && wb_adr_i == CTRL_OFS;
    assign start_wr = ctrl_we && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT];
    assign wr_mask  = {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // One-wait-state acknowledge, every address answered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Last driver index, held at rest after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_q <= LAST_RST;
        end else if (ctrl_we && wb_sel_i[0]) begin
            last_q <= wb_dat_i[CTRL_LAST_LSB +: 2];
        end
    end

    // ************************************************************
    // Sequencer state
    // ************************************************************
    seq_state_e  state_q;
    logic [1:0]  addr_q;
    logic [5:0]  ptr_q;
    logic        data_q;
    logic        sel_q;
    motor_sig_s  snap_q [MOTORS];
    cfg_half_s   cur;
    logic        cur_bit;
    logic        sync1_q;
    logic        sync2_q;
    logic        prev_q;
    logic        lk_rise;
    logic        lk_fall;
    logic        at_last;

    // Read data mux, unmapped reads give zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (bus_req) begin
            rdata_q <= '0;
            if (is_cfg) begin
                rdata_q[11:0] <= ram_rdata;
            end else if (wb_adr_i == CTRL_OFS) begin
                rdata_q[CTRL_LAST_LSB +: 2] <= last_q;
            end else if (wb_adr_i == STATUS_OFS) begin
                rdata_q[STAT_BUSY_BIT]     <= state_q != ST_IDLE;
                rdata_q[STAT_ADDR_LSB +: 2] <= addr_q;
                rdata_q[STAT_PEND_BIT]     <= req_q;
                rdata_q[STAT_PTR_LSB +: 6] <= ptr_q;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ************************************************************
    // Code list storage and signal selection
    // ************************************************************
    // Code list storage, two entries per word
    config_ram #(
        .WORDS      (RAM_WORDS)
    ) u_ram (
        .clk        (clk),
        .nrst       (nrst),
        .host_we    (cfg_we),
        .host_idx   (wb_adr_i[6:2]),
        .host_wdata (wb_dat_i[11:0]),
        .host_mask  (wr_mask),
        .host_rdata (ram_rdata),
        .seq_idx    (ptr_q),
        .seq_half   (cur)
    );

    // Select code to bit for the addressed motor
    signal_select u_sel (
        .snap       (snap_q),
        .motor_addr (addr_q),
        .code       (cur.code),
        .bit_out    (cur_bit)
    );

    // ************************************************************
    // Link clock sampling
    // ************************************************************
    // Two-stage synchroniser, then edge detect on the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= link_clk;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Link edges, last-driver compare
    assign lk_rise = sync2_q && !prev_q;
    assign lk_fall = !sync2_q && prev_q;
    assign at_last = addr_q == last_q;

    // Pending request: motor units or software, set beats clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_q <= 1'b0;
        end else if (tx_request || start_wr) begin
            req_q <= 1'b1;
        end else if (state_q == ST_LOAD) begin
            req_q <= 1'b0;
        end
    end

    // Frame control
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_q) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state_q <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (lk_rise && cur.next_motor_flag && at_last) begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    if (lk_fall) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // List pointer and motor address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q  <= '0;
            addr_q <= '0;
        end else if (state_q != ST_SHIFT) begin
            ptr_q  <= '0;
            addr_q <= '0;
        end else if (state_q == ST_SHIFT && lk_rise) begin
            ptr_q <= ptr_q + 6'h01;
            if (cur.next_motor_flag && !at_last) begin
                addr_q <= addr_q + 2'h1;
            end
        end
    end

    // Snapshot of all motor signals before the first bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < MOTORS; i++) begin
                snap_q[i] <= '0;
            end
        end else if (state_q == ST_LOAD) begin
            for (int i = 0; i < MOTORS; i++) begin
                snap_q[i] <= motor_sig[i];
            end
        end
    end

    // Serial outputs; data follows the selected code
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_q <= 1'b0;
            sel_q  <= 1'b0;
        end else begin
            sel_q  <= state_q == ST_SHIFT || state_q == ST_FINISH;
            if (state_q == ST_SHIFT) begin
                data_q <= cur_bit;
            end
        end
    end

    // Pin outputs
    assign drv_data     = data_q;
    assign drv_select_n = !sel_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Frame sequencing
    a_start_at_zero: assert property (state_q == ST_LOAD
                                      |=> addr_q == 2'h0 && ptr_q == 6'h00)
        else $error("frame did not start at motor zero, entry zero");
    a_idle_addr_zero: assert property (state_q == ST_IDLE |-> addr_q == 2'h0)
        else $error("motor address not zero while idle");
    a_flag_advance: assert property (state_q == ST_SHIFT && lk_rise
                                     && cur.next_motor_flag && !at_last
                                     |=> addr_q == $past(addr_q) + 2'h1)
        else $error("motor address did not advance on flag");
    a_flag_finish: assert property (state_q == ST_SHIFT && lk_rise
                                    && cur.next_motor_flag && at_last
                                    |=> state_q == ST_FINISH)
        else $error("frame did not end at last driver");
    a_endless_run: assert property (state_q == ST_SHIFT && !cur.next_motor_flag
                                    |=> state_q == ST_SHIFT)
        else $error("frame ended without a next-motor flag");
    a_frame_close: assert property (state_q == ST_FINISH && lk_fall
                                    |=> state_q == ST_IDLE ##1 drv_select_n)
        else $error("finished frame did not release the chain");
    a_idle_quiet: assert property (state_q == ST_IDLE |=> drv_select_n)
        else $error("chain selected while idle");
    a_ptr_order: assert property (state_q == ST_SHIFT && lk_rise
                                  |=> ptr_q == $past(ptr_q) + 6'h01)
        else $error("list pointer did not step by one");
    a_snap_stable: assert property (state_q == ST_SHIFT && $past(state_q) == ST_SHIFT
                                    |-> $stable(snap_q[0]) && $stable(snap_q[1])
                                    && $stable(snap_q[2]))
        else $error("snapshot changed during frame");
    a_request_go: assert property (state_q == ST_IDLE && req_q
                                   |=> state_q == ST_LOAD ##1 state_q == ST_SHIFT
                                   ##1 !drv_select_n)
        else $error("request did not open a frame");

    // Code selection
    a_rsvd_zero: assert property (state_q == ST_SHIFT && cur.code >= CODE_RSVD
                                  |=> drv_data == 1'b0)
        else $error("reserved code sent a one");
    a_zero_bit: assert property (state_q == ST_SHIFT && cur.code == CODE_ZERO
                                 |=> !drv_data)
        else $error("constant zero code did not send zero");
    a_const_one: assert property (state_q == ST_SHIFT && cur.code == CODE_ONE
                                  |=> drv_data == 1'b1)
        else $error("constant one code did not send one");
    a_dac_a_bit: assert property (state_q == ST_SHIFT && cur.code < 5'h06
                                  && addr_q == 2'h0
                                  |-> cur_bit == snap_q[0].dac_a[cur.code[2:0]])
        else $error("coil A current bit misselected");
    a_phase_a_bit: assert property (state_q == ST_SHIFT && cur.code == 5'h06
                                    && addr_q != 2'h3
                                    |-> cur_bit == snap_q[addr_q].coil_a_phase_polarity)
        else $error("coil A phase bit misselected");
    a_dac_b_bit: assert property (state_q == ST_SHIFT && cur.code >= CODE_B_BASE
                                  && cur.code < 5'h0E && addr_q != 2'h3
                                  |-> cur_bit == snap_q[addr_q].dac_b[cur.code[2:0]])
        else $error("coil B current bit misselected");
    a_decay_b_bit: assert property (state_q == ST_SHIFT && cur.code == 5'h0F
                                    && addr_q != 2'h3
                                    |-> cur_bit == snap_q[addr_q].coil_b_fast_decay)
        else $error("coil B decay bit misselected");
    a_dir_bit: assert property (state_q == ST_SHIFT && cur.code == CODE_DIR
                                && addr_q != 2'h3 |-> cur_bit == snap_q[addr_q].direction)
        else $error("direction bit misselected");
    a_step_bit: assert property (state_q == ST_SHIFT && cur.code == CODE_STEP
                                 && addr_q != 2'h3 |-> cur_bit == snap_q[addr_q].step)
        else $error("step bit misselected");

    // Register bus
    a_ack_answer: assert property (bus_req |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    // Main scenarios
    c_frame_done: cover property (state_q == ST_FINISH ##1 state_q == ST_IDLE);
    c_motor_step: cover property (state_q == ST_SHIFT && addr_q == 2'h2);
    c_write_busy: cover property (cfg_we && state_q == ST_SHIFT);
    c_wrap_list:  cover property (state_q == ST_SHIFT && ptr_q == 6'h3F && lk_rise);
    c_busy_read:  cover property (bus_req && wb_adr_i == STATUS_OFS && state_q == ST_SHIFT);

endmodule : driver_chain_datagram_sequencer

// >>> hdl/seq_pkg.sv
package seq_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int MOTORS      = 3;     // Motors in the driver chain
    localparam int RAM_WORDS   = 32;    // 12-bit words of the code list
    localparam int HALF_W      = 6;     // Flag plus 5-bit code
    localparam int DEF_LEN     = 12;    // Codes per preset 12-bit driver

    // ************************************************************
    // Register offsets (byte addresses) and fields
    // ************************************************************
    localparam logic [7:0] CFG_OFS    = 8'h00;  // Code list, 32 words
    localparam logic [7:0] CTRL_OFS   = 8'h80;
    localparam logic [7:0] STATUS_OFS = 8'h84;
    localparam int CTRL_START_BIT = 0;          // Write 1 requests a datagram
    localparam int CTRL_LAST_LSB  = 1;          // Last driver index, 2 bits
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ADDR_LSB  = 1;          // Motor address counter, 2 bits
    localparam int STAT_PEND_BIT  = 3;
    localparam int STAT_PTR_LSB   = 8;          // List position, 6 bits
    localparam logic [1:0] LAST_RST = 2'h0;

    // ************************************************************
    // Select codes
    // ************************************************************
    localparam logic [4:0] CODE_A_BASE = 5'h00;
    localparam logic [4:0] CODE_B_BASE = 5'h08;
    localparam logic [4:0] CODE_ZERO   = 5'h10;
    localparam logic [4:0] CODE_ONE    = 5'h11;
    localparam logic [4:0] CODE_DIR    = 5'h12;
    localparam logic [4:0] CODE_STEP   = 5'h13;
    localparam logic [4:0] CODE_RSVD   = 5'h14;  // First reserved code

    // Preset list for one 12-bit driver, flag in bit 5
    localparam logic [5:0] DEF_DRIVER [DEF_LEN] = '{
        6'h11, 6'h05, 6'h04, 6'h03, 6'h02, 6'h06,
        6'h11, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h2E};

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [5:0] dac_a;
        logic       coil_a_phase_polarity;
        logic       coil_a_fast_decay;
        logic [5:0] dac_b;
        logic       coil_b_phase_polarity;
        logic       coil_b_fast_decay;
        logic       direction;
        logic       step;
    } motor_sig_s;

    typedef struct packed {
        logic       next_motor_flag;
        logic [4:0] code;
    } cfg_half_s;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_LOAD   = 4'b0010,
        ST_SHIFT  = 4'b0100,
        ST_FINISH = 4'b1000
    } seq_state_e;

endpackage : seq_pkg

// >>> hdl/config_ram.sv
`timescale 1ns/1ps
module config_ram
    import seq_pkg::*;
#(
    parameter int WORDS = RAM_WORDS
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     host_we,
    input  wire logic [$clog2(WORDS)-1:0] host_idx,
    input  wire logic [11:0]              host_wdata,
    input  wire logic [11:0]              host_mask,
    output logic      [11:0]              host_rdata,
    input  wire logic [$clog2(WORDS):0]   seq_idx,
    output cfg_half_s                     seq_half
);
    localparam int HALVES = 2 * WORDS;

    if (WORDS != RAM_WORDS) begin : g_chk
        $error("config_ram serves exactly 32 words");
    end

    logic [HALF_W-1:0] mem_q [HALVES];

    // Preset code list for a chain of 12-bit drivers
    function automatic logic [HALF_W-1:0] default_half(input int i);
        if (i < DEF_LEN * MOTORS) begin
            return DEF_DRIVER[i % DEF_LEN];
        end
        return '0;
    endfunction : default_half

    // Host writes with byte masking; both halves of one word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < HALVES; i++) begin
                mem_q[i] <= default_half(i);
            end
        end else if (host_we) begin
            mem_q[{host_idx, 1'b0}] <= (mem_q[{host_idx, 1'b0}] & ~host_mask[5:0])
                                     | (host_wdata[5:0] & host_mask[5:0]);
            mem_q[{host_idx, 1'b1}] <= (mem_q[{host_idx, 1'b1}] & ~host_mask[11:6])
                                     | (host_wdata[11:6] & host_mask[11:6]);
        end
    end

    // Two independent read ports, host never blocked
    assign host_rdata = {mem_q[{host_idx, 1'b1}], mem_q[{host_idx, 1'b0}]};
    assign seq_half   = cfg_half_s'(mem_q[seq_idx]);

endmodule : config_ram

// >>> hdl/signal_select.sv
`timescale 1ns/1ps
module signal_select
    import seq_pkg::*;
(
    input  motor_sig_s       snap [MOTORS],
    input  wire logic [1:0]  motor_addr,
    input  wire logic [4:0]  code,
    output logic             bit_out
);
    motor_sig_s m;
    logic [7:0] coil_a;
    logic [7:0] coil_b;

    // Pick one signal of the addressed motor
    always_comb begin
        m = snap[0];
        if (int'(motor_addr) < MOTORS) begin
            m = snap[motor_addr];
        end
        coil_a  = {m.coil_a_fast_decay, m.coil_a_phase_polarity, m.dac_a};
        coil_b  = {m.coil_b_fast_decay, m.coil_b_phase_polarity, m.dac_b};
        bit_out = 1'b0;
        if (code < CODE_B_BASE) begin
            bit_out = coil_a[code[2:0]];
        end else if (code < CODE_ZERO) begin
            bit_out = coil_b[code[2:0]];
        end else if (code == CODE_ONE) begin
            bit_out = 1'b1;
        end else if (code == CODE_DIR) begin
            bit_out = m.direction;
        end else if (code == CODE_STEP) begin
            bit_out = m.step;
        end
    end

endmodule : signal_select

// >>> verification/chain_partner.sv
`timescale 1ns/1ps
// ************************************************************
// Driver chain model
// ************************************************************
module chain_partner (
    input  wire logic drv_data,
    input  wire logic drv_select_n,
    output logic      link_clk
);
    logic bits [$];  // Bits shifted in, oldest first

    // Shift clock toggles only while the chain is selected
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            #80;
            if (drv_select_n === 1'b0) begin
                link_clk = ~link_clk;
            end else begin
                link_clk = 1'b0;
            end
        end
    end

    // Bit taken on each rising shift edge in a frame
    always @(posedge link_clk) begin
        if (drv_select_n === 1'b0) begin
            bits.push_back(drv_data);
        end
    end
endmodule : chain_partner

// >>> verification/driver_chain_datagram_sequencer_tb.sv
`timescale 1ns/1ps
module driver_chain_datagram_sequencer_tb
    import seq_pkg::*;
;
    // ************************************************************
    // Bench signals
    // ************************************************************
    logic        clk = 1'b0;
    logic        nrst;
    logic        wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, tx_request, drv_data, drv_select_n;
    wire         link_clk;
    motor_sig_s  sig [MOTORS];
    logic        exp_bits [$];
    int          miscompares, samples_checked, cycles;

    // System clock
    always #10 clk = ~clk;

    driver_chain_datagram_sequencer uut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motor_sig(sig),
        .tx_request(tx_request), .link_clk(link_clk), .drv_data(drv_data),
        .drv_select_n(drv_select_n));

    chain_partner partner (.drv_data(drv_data), .drv_select_n(drv_select_n),
        .link_clk(link_clk));

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            $display("[FAIL] run time expected below 40000 seen 40000");
            wrap_up();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    // Classic single cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        check_word("ack latency", 32'h2, 32'(n));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_cycle

    task automatic wait_sel(input logic lvl, input int lim);
        int n;
        n = 0;
        while (drv_select_n !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        check_word("select_n", {31'h0, lvl}, {31'h0, drv_select_n});
    endtask : wait_sel

    // Request one datagram and wait for the frame to open
    task automatic start_frame();
        partner.bits.delete();
        @(posedge clk);
        tx_request <= 1'b1;
        @(posedge clk);
        tx_request <= 1'b0;
        wait_sel(1'b0, 20);
    endtask : start_frame

    task automatic finish_frame(input int n);
        int sz;
        wait_sel(1'b1, 4000);
        sz = partner.bits.size();
        check_word("bit count", 32'(n), 32'(sz));
        for (int i = 0; i < n && i < sz; i++) begin
            check_word("stream bit", {31'h0, exp_bits[i]}, {31'h0, partner.bits[i]});
        end
    endtask : finish_frame

    function automatic logic code_bit(input motor_sig_s s, input logic [4:0] c);
        logic [7:0] a;
        logic [7:0] b;
        a = {s.coil_a_fast_decay, s.coil_a_phase_polarity, s.dac_a};
        b = {s.coil_b_fast_decay, s.coil_b_phase_polarity, s.dac_b};
        if (c < 5'h08) return a[c[2:0]];
        if (c < 5'h10) return b[c[2:0]];
        if (c == CODE_ONE) return 1'b1;
        if (c == CODE_DIR) return s.direction;
        if (c == CODE_STEP) return s.step;
        return 1'b0;
    endfunction : code_bit

    // ************************************************************
    // Tests
    // ************************************************************
    task automatic test_reset();
        logic [31:0] v;
        logic [5:0]  e0, e1;
        check_word("select_n", 32'h1, {31'h0, drv_select_n});
        check_word("data", 32'h0, {31'h0, drv_data});
        repeat (40) @(posedge clk);
        check_word("idle bits", 32'h0, 32'(partner.bits.size()));
        for (int w = 0; w < RAM_WORDS; w++) begin
            e0 = (2 * w < 36) ? DEF_DRIVER[(2 * w) % 12] : 6'h00;
            e1 = (2 * w + 1 < 36) ? DEF_DRIVER[(2 * w + 1) % 12] : 6'h00;
            wb_cycle(1'b0, 8'(4 * w), 32'h0, v);
            check_word("preset word", {20'h0, e1, e0}, v);
        end
        wb_cycle(1'b0, CTRL_OFS, 32'h0, v);
        check_word("last index", {30'h0, LAST_RST}, {30'h0, v[2:1]});
        wb_cycle(1'b0, 8'hC0, 32'h0, v);
        check_word("unmapped", 32'h0, v);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_preset_frame();
        logic [31:0] v;
        exp_bits.delete();
        for (int i = 0; i < DEF_LEN; i++) exp_bits.push_back(code_bit(sig[0], DEF_DRIVER[i][4:0]));
        start_frame();
        finish_frame(DEF_LEN);
        wb_cycle(1'b0, STATUS_OFS, 32'h0, v);
        check_word("status idle", 32'h0, {29'h0, v[2:0]});
        $display("test_preset_frame done");
    endtask : test_preset_frame

    task automatic test_all_codes();
        logic [5:0]  lst [64];
        logic [31:0] v;
        int          m;
        exp_bits.delete();
        for (int i = 0; i < 64; i++) begin
            lst[i] = (i < 40) ? 6'(i % 32) : 6'h00;
            if (i == 15 || i == 31 || i == 39) lst[i][5] = 1'b1;
            m = (i < 16) ? 0 : (i < 32) ? 1 : 2;
            if (i < 40) exp_bits.push_back(code_bit(sig[m], lst[i][4:0]));
        end
        for (int w = 0; w < RAM_WORDS; w++) begin
            wb_cycle(1'b1, 8'(4 * w), {20'h0, lst[2 * w + 1], lst[2 * w]}, v);
        end
        wb_cycle(1'b1, CTRL_OFS, 32'h4, v);
        start_frame();
        for (int k = 0; k < MOTORS; k++) sig[k] <= ~sig[k];
        finish_frame(40);
        for (int k = 0; k < MOTORS; k++) sig[k] <= ~sig[k];
        $display("test_all_codes done");
    endtask : test_all_codes

    task automatic test_endless();
        logic [31:0] v;
        int          n;
        partner.bits.delete();
        for (int w = 0; w < RAM_WORDS; w++) wb_cycle(1'b1, 8'(4 * w), 32'h451, v);
        wb_cycle(1'b1, CTRL_OFS, 32'h1, v);
        wait_sel(1'b0, 20);
        n = 0;
        while (partner.bits.size() < 80 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check_word("select_n", 32'h0, {31'h0, drv_select_n});
        wb_cycle(1'b0, STATUS_OFS, 32'h0, v);
        check_word("busy", 32'h1, {31'h0, v[0]});
        wb_cycle(1'b1, CFG_OFS + 8'h14, 32'h514, v);
        wb_cycle(1'b0, CFG_OFS + 8'h14, 32'h0, v);
        check_word("word during frame", 32'h514, v);
        wb_cycle(1'b1, CFG_OFS, 32'h471, v);
        wait_sel(1'b1, 3000);
        wb_cycle(1'b0, STATUS_OFS, 32'h0, v);
        check_word("status idle", 32'h0, {29'h0, v[2:0]});
        $display("test_endless done");
    endtask : test_endless

    // ************************************************************
    // Main
    // ************************************************************
    initial begin
        nrst       = 1'b0;
        wb_cyc_i   = 1'b0;
        wb_stb_i   = 1'b0;
        wb_we_i    = 1'b0;
        wb_adr_i   = 8'h00;
        wb_sel_i   = 4'h0;
        wb_dat_i   = 32'h0;
        tx_request = 1'b0;
        sig[0]     = motor_sig_s'(16'hA5C3);
        sig[1]     = motor_sig_s'(16'h3C96);
        sig[2]     = motor_sig_s'(16'h5A0F);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        test_preset_frame();
        test_all_codes();
        test_endless();
        wrap_up();
    end
endmodule : driver_chain_datagram_sequencer_tb
